// *** src/hw_loop_pkg.sv ***
// Purpose: Shared constants and carriers of the two-level hardware loop unit
// Assumes: 32-bit fetch addresses, 32-bit setup instruction length
// Notes: Register offsets are byte addresses on the plain register port
package hw_loop_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int LEVELS = 2;
   localparam int REG_ADDR_W = 8;

   // Register offsets
   localparam logic [REG_ADDR_W-1:0] OFF_TOP0 = 8'h00;
   localparam logic [REG_ADDR_W-1:0] OFF_BOT0 = 8'h04;
   localparam logic [REG_ADDR_W-1:0] OFF_CNT0 = 8'h08;
   localparam logic [REG_ADDR_W-1:0] OFF_TOP1 = 8'h0C;
   localparam logic [REG_ADDR_W-1:0] OFF_BOT1 = 8'h10;
   localparam logic [REG_ADDR_W-1:0] OFF_CNT1 = 8'h14;
   localparam logic [REG_ADDR_W-1:0] OFF_STATUS = 8'h18;

   // Status register fields
   localparam int STAT_ACT0_BIT = 0;
   localparam int STAT_ACT1_BIT = 1;
   localparam int STAT_REJ_BIT = 2;

   // Reset values
   localparam logic [DATA_W-1:0] LOOP_REG_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

   // Setup offset ranges, even values only
   localparam logic [4:0] TOP_OFF_MIN = 5'h04;
   localparam logic [4:0] TOP_OFF_MAX = 5'h1E;
   localparam logic [10:0] BOT_OFF_MIN = 11'h004;
   localparam logic [10:0] BOT_OFF_MAX = 11'h7FE;

   // Length of the setup instruction; a top at this offset needs no redirect
   localparam logic [4:0] SETUP_LEN = 5'h04;

   localparam logic [DATA_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] CNT_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      CNT_KEEP,
      CNT_PTR,
      CNT_PTR_HALF
   } count_src_e;

   typedef struct packed {
      logic valid;
      logic parallel;
      logic level;
      logic [4:0] topOff;
      logic [10:0] botOff;
      count_src_e cntSrc;
      logic [DATA_W-1:0] pointerVal;
      logic [ADDR_W-1:0] pc;
   } setup_req_s;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] target;
   } redirect_s;

endpackage : hw_loop_pkg

// *** src/zero_overhead_hw_loop.sv ***
// Purpose: Two-level zero-overhead hardware loop unit of the program sequencer
// Assumes: Fetch address, setup request and register port come from logic on clk_sys
// Notes: Redirect and flush follow the fetch or setup that causes them by one cycle
//        A software write beats a same-cycle decrement or setup load
//
// Summary of operation
// - Two nestable levels, each top, bottom, counter
// - Bottom hit, count above one: decrement, jump top
// - Counter tested only at loop bottom
// - Zero count: no decrement, no loopback
// - Count one: decrement only, fall through
// - Counters are 32-bit unsigned registers
// - Top is PC plus unsigned 5-bit even offset
// - Bottom is PC plus unsigned 11-bit offset
// - Setup loads top, bottom and, unless CNT_KEEP, count from pointer
// - Counter designation selects level zero or one
// - Entry redirect only when top not sequential
// - Equal bottoms: level one inner, zero outer
// - Loop registers writable with full 32 bits
// - Loop registers readable and writable by software
// - No active-register writes in last instruction; not enforced, such a write still wins
// - Setup in a parallel group is rejected
// - Top offset 4 to 30, bottom 4 to 2046
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module zero_overhead_hw_loop
   import hw_loop_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic fetchValid,
   input wire logic [ADDR_W-1:0] fetchAddr,
   input wire setup_req_s setupReq,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output redirect_s redirect_q,
   output logic flushSeq_q,
   output logic setupDone_q,
   output logic setupReject_q,
   output logic [DATA_W-1:0] regRdData_q
);

   logic [ADDR_W-1:0] loopTop_q [LEVELS];
   logic [ADDR_W-1:0] loopBot_q [LEVELS];
   logic [DATA_W-1:0] loopCnt_q [LEVELS];
   logic lastSetupRej_q;

   logic [ADDR_W-1:0] loopTop_d [LEVELS];
   logic [ADDR_W-1:0] loopBot_d [LEVELS];
   logic [DATA_W-1:0] loopCnt_d [LEVELS];

   logic [LEVELS-1:0] bottomHit;
   logic [LEVELS-1:0] takeBack;
   logic setupOk;
   logic setupBad;
   logic [ADDR_W-1:0] setupTop;
   logic [ADDR_W-1:0] setupBot;
   logic [DATA_W-1:0] setupCnt;
   logic entryJump;
   redirect_s redirect_d;
   logic [DATA_W-1:0] rdData_d;

   function automatic logic [ADDR_W-1:0] pcPlus(input logic [ADDR_W-1:0] pc,
                                                 input logic [10:0] off);
      pcPlus = pc + {{(ADDR_W-11){1'b0}}, off};
   endfunction : pcPlus

   function automatic logic evenInRange(input logic [10:0] off,
                                        input logic [10:0] lo,
                                        input logic [10:0] hi);
      evenInRange = !off[0] && (off >= lo) && (off <= hi);
   endfunction : evenInRange

   function automatic logic regHit(input logic [REG_ADDR_W-1:0] addr,
                                   input logic [REG_ADDR_W-1:0] off0,
                                   input logic [REG_ADDR_W-1:0] off1,
                                   input int lvl);
      regHit = (lvl == 0) ? (addr == off0) : (addr == off1);
   endfunction : regHit

   // A level whose counter is zero is idle and ignores its bottom
   function automatic logic levelArmed(input logic [DATA_W-1:0] cnt);
      levelArmed = cnt != CNT_ZERO;
   endfunction : levelArmed

   // The last trip still decrements, but falls through past the bottom
   function automatic logic lastTrip(input logic [DATA_W-1:0] cnt);
      lastTrip = cnt == CNT_ONE;
   endfunction : lastTrip

   // Bottom compare of one level against the current fetch
   function automatic logic atBottom(input logic valid,
                                     input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] bot);
      atBottom = valid && (addr == bot);
   endfunction : atBottom

   // Accepted setup aimed at the given level
   function automatic logic setupFor(input logic ok, input logic lvl, input int i);
      setupFor = ok && (lvl == i[0]);
   endfunction : setupFor

   // Setup decode; a refused setup leaves every loop register untouched
   always_comb begin
      setupBad = setupReq.parallel;
      if (!evenInRange({6'h00, setupReq.topOff}, {6'h00, TOP_OFF_MIN},
                       {6'h00, TOP_OFF_MAX})) begin
         setupBad = 1'b1;
      end
      if (!evenInRange(setupReq.botOff, BOT_OFF_MIN, BOT_OFF_MAX)) begin
         setupBad = 1'b1;
      end
      setupOk = setupReq.valid && !setupBad;
      // Unsigned offsets only, so a loop can never start behind the setup
      setupTop = pcPlus(setupReq.pc, {6'h00, setupReq.topOff});
      setupBot = pcPlus(setupReq.pc, setupReq.botOff);
      unique case (setupReq.cntSrc)
         CNT_PTR: setupCnt = setupReq.pointerVal;
         CNT_PTR_HALF: setupCnt = setupReq.pointerVal >> 1;
         default: setupCnt = CNT_ZERO;
      endcase
      entryJump = setupOk && (setupReq.topOff != SETUP_LEN);
   end

   // Bottom detection; level one is looked at first as the inner loop
   always_comb begin
      bottomHit[1] = atBottom(fetchValid, fetchAddr, loopBot_q[1]) &&
                     levelArmed(loopCnt_q[1]);
      takeBack[1] = bottomHit[1] && !lastTrip(loopCnt_q[1]);
      // Outer level acts only when the inner level takes no loopback
      bottomHit[0] = !takeBack[1] && atBottom(fetchValid, fetchAddr, loopBot_q[0]) &&
                     levelArmed(loopCnt_q[0]);
      takeBack[0] = bottomHit[0] && !lastTrip(loopCnt_q[0]);
   end

   // Next values of the loop registers; a software write wins the cycle
   always_comb begin
      for (int i = 0; i < LEVELS; i++) begin
         loopTop_d[i] = loopTop_q[i];
         if (setupFor(setupOk, setupReq.level, i)) begin
            loopTop_d[i] = setupTop;
         end
         // Writes in the last loop instruction collide with a loopback;
         // software must keep clear of that slot, the write wins regardless
         if (regWr && regHit(regAddr, OFF_TOP0, OFF_TOP1, i)) begin
            loopTop_d[i] = regWrData;
         end
      end
   end

   // Bottoms follow the same precedence as the tops
   always_comb begin
      for (int i = 0; i < LEVELS; i++) begin
         loopBot_d[i] = loopBot_q[i];
         if (setupFor(setupOk, setupReq.level, i)) begin
            loopBot_d[i] = setupBot;
         end
         if (regWr && regHit(regAddr, OFF_BOT0, OFF_BOT1, i)) begin
            loopBot_d[i] = regWrData;
         end
      end
   end

   // Decrement, then setup load, then software write, lowest first
   always_comb begin
      for (int i = 0; i < LEVELS; i++) begin
         loopCnt_d[i] = loopCnt_q[i];
         if (bottomHit[i]) begin
            loopCnt_d[i] = loopCnt_q[i] - CNT_ONE;
         end
         if (setupFor(setupOk, setupReq.level, i) && (setupReq.cntSrc != CNT_KEEP)) begin
            loopCnt_d[i] = setupCnt;
         end
         // Counter written last arms the level with valid pointers
         if (regWr && regHit(regAddr, OFF_CNT0, OFF_CNT1, i)) begin
            loopCnt_d[i] = regWrData;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < LEVELS; i++) begin
         if (sys_rst) begin
            loopTop_q[i] <= LOOP_REG_RST;
         end else begin
            loopTop_q[i] <= loopTop_d[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < LEVELS; i++) begin
         if (sys_rst) begin
            loopBot_q[i] <= LOOP_REG_RST;
         end else begin
            loopBot_q[i] <= loopBot_d[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < LEVELS; i++) begin
         if (sys_rst) begin
            loopCnt_q[i] <= LOOP_REG_RST;
         end else begin
            loopCnt_q[i] <= loopCnt_d[i];
         end
      end
   end

   // Redirect: setup entry jump has precedence over a loopback
   always_comb begin
      redirect_d.valid = 1'b0;
      redirect_d.target = '0;
      if (entryJump) begin
         redirect_d.valid = 1'b1;
         redirect_d.target = setupTop;
      end else if (takeBack[1]) begin
         redirect_d.valid = 1'b1;
         redirect_d.target = loopTop_q[1];
      end else if (takeBack[0]) begin
         redirect_d.valid = 1'b1;
         redirect_d.target = loopTop_q[0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         redirect_q <= '0;
         flushSeq_q <= 1'b0;
      end else begin
         redirect_q <= redirect_d;
         // Sequential fetches past the bottom are already in flight
         flushSeq_q <= redirect_d.valid;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         setupDone_q <= 1'b0;
         setupReject_q <= 1'b0;
         lastSetupRej_q <= 1'b0;
      end else begin
         setupDone_q <= setupOk;
         setupReject_q <= setupReq.valid && setupBad;
         if (setupReq.valid) begin
            lastSetupRej_q <= setupBad;
         end
      end
   end

   // Register read port; status is read only, writes to it land nowhere
   always_comb begin
      rdData_d = READ_IDLE;
      unique case (regAddr)
         OFF_TOP0: rdData_d = loopTop_q[0];
         OFF_BOT0: rdData_d = loopBot_q[0];
         OFF_CNT0: rdData_d = loopCnt_q[0];
         OFF_TOP1: rdData_d = loopTop_q[1];
         OFF_BOT1: rdData_d = loopBot_q[1];
         OFF_CNT1: rdData_d = loopCnt_q[1];
         OFF_STATUS: begin
            rdData_d[STAT_ACT0_BIT] = levelArmed(loopCnt_q[0]);
            rdData_d[STAT_ACT1_BIT] = levelArmed(loopCnt_q[1]);
            rdData_d[STAT_REJ_BIT] = lastSetupRej_q;
         end
         default: rdData_d = READ_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdData_q <= READ_IDLE;
      end else if (regRd) begin
         regRdData_q <= rdData_d;
      end else begin
         // Data stand only in the cycle after the strobe
         regRdData_q <= READ_IDLE;
      end
   end

endmodule : zero_overhead_hw_loop

// *** verification/hw_loop_assertions.sv ***
// Purpose: Port checks of the hardware loop unit
// Assumes: One clock, synchronous reset
// Notes: Attached by bind below
`timescale 1ns/1ps
module hw_loop_assertions
   import hw_loop_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic fetchValid,
   input wire logic [ADDR_W-1:0] fetchAddr,
   input wire setup_req_s setupReq,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire redirect_s redirect_q,
   input wire logic flushSeq_q,
   input wire logic setupDone_q,
   input wire logic setupReject_q,
   input wire logic [DATA_W-1:0] regRdData_q
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Offsets the hardware accepts; anything else must be refused
   wire okS = !setupReq.parallel && !setupReq.topOff[0] && !setupReq.botOff[0]
      && setupReq.topOff >= 5'h04 && setupReq.topOff <= 5'h1E
      && setupReq.botOff >= 11'h004 && setupReq.botOff <= 11'h7FE;
   property p_rd; !$past(regRd) |-> regRdData_q == READ_IDLE; endproperty
   a_rd: assert property (p_rd) else $error("read data out of slot");
   property p_tgt; !redirect_q.valid |-> redirect_q.target == '0; endproperty
   a_tgt: assert property (p_tgt) else $error("target without redirect");
   property p_flush; flushSeq_q == redirect_q.valid; endproperty
   a_flush: assert property (p_flush) else $error("flush not with redirect");
   property p_par; setupReq.valid && setupReq.parallel |=> setupReject_q; endproperty
   a_par: assert property (p_par) else $error("parallel setup taken");
   property p_odd;
      setupReq.valid && (setupReq.topOff[0] || setupReq.botOff[0]) |=> setupReject_q;
   endproperty
   a_odd: assert property (p_odd) else $error("odd offset taken");
   property p_quiet; !setupReq.valid |=> !setupDone_q && !setupReject_q; endproperty
   a_quiet: assert property (p_quiet) else $error("setup answer unasked");
   property p_entry;
      setupReq.valid && okS && setupReq.topOff != 5'h04 |=> redirect_q.valid
         && redirect_q.target == $past(setupReq.pc) + $past(setupReq.topOff);
   endproperty
   a_entry: assert property (p_entry) else $error("entry redirect wrong");
   property p_cause;
      redirect_q.valid |-> $past(fetchValid) || $past(setupReq.valid);
   endproperty
   a_cause: assert property (p_cause) else $error("redirect without cause");
   c_loop: cover property (redirect_q.valid && !$past(setupReq.valid));
   c_done: cover property (setupDone_q);
   c_rej: cover property (setupReject_q);
endmodule : hw_loop_assertions

bind zero_overhead_hw_loop hw_loop_assertions chk (.clk_sys, .sys_rst, .fetchValid,
   .fetchAddr, .setupReq, .regAddr, .regWrData, .regWr, .regRd, .redirect_q,
   .flushSeq_q, .setupDone_q, .setupReject_q, .regRdData_q);

// *** verification/fetch_model.sv ***
// Purpose: Fetch unit stand-in that follows redirects
// Assumes: One 4-byte fetch a cycle while run is high
// Notes: The fetch beside a redirect is dropped
`timescale 1ns/1ps
module fetch_model
   import hw_loop_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic load,
   input wire logic [ADDR_W-1:0] startAddr,
   input wire redirect_s redirect_q,
   input wire logic flushSeq_q,
   output logic fetchValid,
   output logic [ADDR_W-1:0] fetchAddr
);
   logic [ADDR_W-1:0] pc_q;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) pc_q <= '0;
      else if (load) pc_q <= startAddr;
      else if (redirect_q.valid) pc_q <= redirect_q.target;
      else if (run) pc_q <= pc_q + 32'h0000_0004;
   end
   assign fetchValid = run && !flushSeq_q;
   // Idle address is inverted so a stale bottom match cannot slip through
   assign fetchAddr = fetchValid ? pc_q : ~pc_q;
endmodule : fetch_model

// *** verification/tb.sv ***
// Purpose: Directed bench of the hardware loop unit
// Assumes: 20 MHz clk_sys
// Notes: Loop passes are counted at the bottom fetch
`timescale 1ns/1ps
module tb;
   import hw_loop_pkg::*;
   logic clk_sys = 0, sys_rst = 1, run = 0, load = 0, regWr = 0, regRd = 0;
   logic fetchValid, flushSeq_q, setupDone_q, setupReject_q;
   logic [ADDR_W-1:0] startAddr = '0, fetchAddr;
   logic [REG_ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0, regRdData_q;
   setup_req_s setupReq = '0;
   redirect_s redirect_q;
   int error_cnt = 0, num_checks = 0, cyc = 0, hits;
   initial forever #25 clk_sys = ~clk_sys;
   zero_overhead_hw_loop DUT (.clk_sys, .sys_rst, .fetchValid, .fetchAddr, .setupReq,
      .regAddr, .regWrData, .regWr, .regRd, .redirect_q, .flushSeq_q, .setupDone_q,
      .setupReject_q, .regRdData_q);
   fetch_model fm (.clk_sys, .sys_rst, .run, .load, .startAddr, .redirect_q, .flushSeq_q,
      .fetchValid, .fetchAddr);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regRd <= 1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 0;
      #1 chk(regRdData_q, e);
   endtask : rdc
   task automatic setup(input logic l, p, input logic [4:0] t, input logic [10:0] b,
         input count_src_e s, input logic [31:0] v, a);
      logic ok;
      ok = !p && !t[0] && !b[0] && t >= 5'h04 && t <= 5'h1E && b >= 11'h004 && b <= 11'h7FE;
      @(posedge clk_sys);
      setupReq <= '{1'b1, p, l, t, b, s, v, a};
      @(posedge clk_sys);
      setupReq.valid <= 1'b0;
      #1 chk(setupDone_q, ok);
      chk(setupReject_q, !ok);
      chk(redirect_q.valid, ok && t != 5'h04);
      chk(flushSeq_q, ok && t != 5'h04);
      if (ok && t != 5'h04) chk(redirect_q.target, a + t);
   endtask : setup
   // Fixed run length: the fetch model never stalls, so passes settle well inside it
   task automatic loop_run(input logic [31:0] s, bot, input int n, exp);
      hits = 0;
      @(posedge clk_sys);
      load <= 1;
      startAddr <= s;
      @(posedge clk_sys);
      load <= 0;
      run <= 1;
      // Fetches are counted mid-cycle, where they have settled
      repeat (n) begin
         @(negedge clk_sys);
         if (fetchValid && fetchAddr === bot) hits++;
      end
      @(posedge clk_sys);
      run <= 0;
      chk(hits, exp);
   endtask : loop_run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 0;
      for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0000_0000);
      wr(OFF_TOP0, 32'h0000_0100);
      wr(OFF_BOT0, 32'h0000_0108);
      wr(OFF_CNT0, 32'h0000_0003);
      rdc(OFF_STATUS, 32'h0000_0001);
      loop_run(32'h0000_0100, 32'h0000_0108, 20, 3);
      rdc(OFF_CNT0, 32'h0000_0000);
      loop_run(32'h0000_0100, 32'h0000_0108, 20, 1);
      wr(OFF_TOP1, 32'hFFFF_FFF0);
      rdc(OFF_TOP1, 32'hFFFF_FFF0);
      wr(OFF_CNT1, 32'hFFFF_FFFE);
      rdc(OFF_CNT1, 32'hFFFF_FFFE);
      rdc(OFF_STATUS, 32'h0000_0002);
      wr(OFF_TOP1, 32'h0000_0200);
      wr(OFF_BOT1, 32'h0000_0208);
      wr(OFF_CNT1, 32'h0000_0002);
      wr(OFF_TOP0, 32'h0000_01FC);
      wr(OFF_BOT0, 32'h0000_0208);
      wr(OFF_CNT0, 32'h0000_0002);
      loop_run(32'h0000_01FC, 32'h0000_0208, 30, 3);
      setup(1, 0, 5'h04, 11'h008, CNT_PTR, 32'h0000_0003, 32'h0000_0400);
      rdc(OFF_TOP1, 32'h0000_0404);
      rdc(OFF_BOT1, 32'h0000_0408);
      rdc(OFF_CNT1, 32'h0000_0003);
      setup(0, 0, 5'h1E, 11'h7FE, CNT_PTR_HALF, 32'h0000_0007, 32'hFFFF_F000);
      rdc(OFF_BOT0, 32'hFFFF_F7FE);
      setup(0, 0, 5'h06, 11'h004, CNT_KEEP, 32'h0000_0009, 32'h0000_0000);
      rdc(OFF_CNT0, 32'h0000_0003);
      loop_run(32'h0000_0404, 32'h0000_0408, 20, 3);
      setup(1, 1, 5'h04, 11'h008, CNT_PTR, 32'h0000_0005, 32'h0000_0400);
      setup(1, 0, 5'h02, 11'h008, CNT_PTR, 32'h0000_0005, 32'h0000_0400);
      setup(1, 0, 5'h05, 11'h009, CNT_PTR, 32'h0000_0005, 32'h0000_0400);
      setup(1, 0, 5'h04, 11'h002, CNT_PTR, 32'h0000_0005, 32'h0000_0400);
      rdc(OFF_CNT1, 32'h0000_0000);
      wr(OFF_STATUS, 32'hFFFF_FFFF);
      wr(8'h1C, 32'hFFFF_FFFF);
      rdc(8'h1C, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0005);
      // Reset between runs must disarm both levels and clear the reject flag
      @(posedge clk_sys);
      sys_rst <= 1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 0;
      rdc(OFF_CNT0, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0000);
      conclude();
   end
endmodule : tb
